// >>> rx_status_pkg.sv
package rx_status_pkg;

   // port count and field widths
   localparam int NUM_PORTS = 4;
   localparam int PORT_W = 2;
   localparam int STATUS_W = 8;
   localparam int PAR_CNT_W = 16;

   // field positions of receive_port_status_one
   localparam int PORT_NUM_HI = 7;
   localparam int PORT_NUM_LO = 6;
   localparam int CRC_FAULT_BIT = 5;
   localparam int LOCK_CHANGE_BIT = 4;
   localparam int SEQ_SUMMARY_BIT = 3;
   localparam int PARITY_BIT = 2;
   localparam int PASS_BIT = 1;
   localparam int LOCKED_BIT = 0;

   // values after reset
   localparam logic [7:0] STATUS_RESET = 8'h00;
   localparam logic [1:0] PORT_RESET = 2'h0;
   localparam logic FLAG_RESET = 1'b0;

endpackage : rx_status_pkg

// >>> sticky_flag.sv
`timescale 1ns/1ps

// sticky event flag: a set in the same cycle as a clear wins
module sticky_flag
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // control
   input wire logic setEvt,
   input wire logic clrEvt,
   // state
   output logic flag
);

   logic flag_ff;
   logic nxt_flag;

   always_comb
   begin
      nxt_flag = flag_ff;
      if (clrEvt)
      begin
         nxt_flag = 1'b0;
      end
      if (setEvt)
      begin
         nxt_flag = 1'b1;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         flag_ff <= rx_status_pkg::FLAG_RESET;
      end
      else
      begin
         flag_ff <= nxt_flag;
      end
   end

   assign flag = flag_ff;

endmodule : sticky_flag

// >>> rx_port_status_one.sv
// Function
// - bits 7:6 read back the index of the receive port selected for reads, read-only.
// - bit 5 latches a forward control-channel CRC error and clears when the register is read.
// - bit 4 latches any change of receiver lock since the last read and clears on read.
// - with enhanced fault reporting off, bit 3 latches a sequence error and clears on read.
// - with enhanced fault reporting on, bit 3 is a fault summary cleared only by a detail read.
// - bit 2 sets while the parity error count exceeds the limit and clears only with the count.
// - bit 1 shows the live pass indication of the selected receiver.
// - bit 0 shows the live lock state of the selected receiver.
// - the two-bit read-port field chooses which port's copy is read, 0 to 3 for ports 0 to 3.
`timescale 1ns/1ps

module rx_port_status_one
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // register read port
   input wire logic [1:0] readPort,
   input wire logic statusRead,
   input wire logic detailRead,
   output logic [7:0] rdData,
   output logic rdValid,
   // configuration
   input wire logic [3:0] enhancedFaultEnable,
   input wire logic [3:0][15:0] parityLimit,
   input wire logic [3:0][15:0] parityFaultCount,
   input wire logic [3:0] parityCountClear,
   // receiver events and states
   input wire logic [3:0] ctrlChannelCrcFault,
   input wire logic [3:0] ctrlChannelSequenceFault,
   input wire logic [3:0] ctrlChannelAnyFault,
   input wire logic [3:0] receiverLocked,
   input wire logic [3:0] portPass
);

   // count strictly above the limit
   function automatic logic overLimit(input logic [15:0] cnt, input logic [15:0] lim);
      overLimit = (cnt > lim);
   endfunction : overLimit

   // one-hot decode of the read port, shared by the status-read and detail-read clearing paths
   function automatic logic [3:0] portSel(input logic [1:0] port);
      portSel = 4'h0;
      portSel[port] = 1'b1;
   endfunction : portSel

   logic [3:0] selOneHot;
   logic [3:0] readClr;
   logic [3:0] detailClr;
   logic [3:0] seqReadClr;
   logic [3:0] lockToggle;
   logic [3:0] parityOver;

   logic [3:0] crcFlag;
   logic [3:0] lockChgFlag;
   logic [3:0] seqFlag;
   logic [3:0] summaryFlag;
   logic [3:0] parityFlag;

   logic [3:0] lockPrev_ff;
   logic [3:0] nxt_lockPrev;

   logic [7:0] rdData_ff;
   logic [7:0] nxt_rdData;
   logic rdValid_ff;
   logic nxt_rdValid;
   logic [7:0] snapshot;

   // read clears only touch the port currently paged in
   always_comb
   begin
      selOneHot = portSel(readPort);
      readClr = statusRead ? selOneHot : 4'h0;
      detailClr = detailRead ? selOneHot : 4'h0;
      seqReadClr = readClr & ~enhancedFaultEnable;
   end

   // lock change and parity threshold detection
   always_comb
   begin
      lockToggle = receiverLocked ^ lockPrev_ff;
      nxt_lockPrev = receiverLocked;
      for (int p = 0; p < rx_status_pkg::NUM_PORTS; p++)
      begin
         parityOver[p] = overLimit(parityFaultCount[p], parityLimit[p]);
      end
   end

   // lock history starts unlocked, so a lock after reset reports a change
   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         lockPrev_ff <= {rx_status_pkg::NUM_PORTS{rx_status_pkg::FLAG_RESET}};
      end
      else
      begin
         lockPrev_ff <= nxt_lockPrev;
      end
   end

   // per-port sticky flags
   for (genvar g = 0; g < rx_status_pkg::NUM_PORTS; g++)
   begin : gPort
      sticky_flag uCrc
      (
         .clk(clk),
         .resetn(resetn),
         .setEvt(ctrlChannelCrcFault[g]),
         .clrEvt(readClr[g]),
         .flag(crcFlag[g])
      );
      sticky_flag uLockChg
      (
         .clk(clk),
         .resetn(resetn),
         .setEvt(lockToggle[g]),
         .clrEvt(readClr[g]),
         .flag(lockChgFlag[g])
      );
      // sequence flag keeps collecting in enhanced mode but is only cleared when visible
      sticky_flag uSeq
      (
         .clk(clk),
         .resetn(resetn),
         .setEvt(ctrlChannelSequenceFault[g]),
         .clrEvt(seqReadClr[g]),
         .flag(seqFlag[g])
      );
      sticky_flag uSummary
      (
         .clk(clk),
         .resetn(resetn),
         .setEvt(ctrlChannelAnyFault[g]),
         .clrEvt(detailClr[g]),
         .flag(summaryFlag[g])
      );
      // set while over the limit, so a clear with the count still high does not stick
      sticky_flag uParity
      (
         .clk(clk),
         .resetn(resetn),
         .setEvt(parityOver[g]),
         .clrEvt(parityCountClear[g]),
         .flag(parityFlag[g])
      );
   end

   // compose the selected port's byte from pre-clear values
   always_comb
   begin
      snapshot = rx_status_pkg::STATUS_RESET;
      snapshot[rx_status_pkg::PORT_NUM_HI:rx_status_pkg::PORT_NUM_LO] = readPort;
      snapshot[rx_status_pkg::CRC_FAULT_BIT] = crcFlag[readPort];
      snapshot[rx_status_pkg::LOCK_CHANGE_BIT] = lockChgFlag[readPort];
      if (enhancedFaultEnable[readPort])
      begin
         snapshot[rx_status_pkg::SEQ_SUMMARY_BIT] = summaryFlag[readPort];
      end
      else
      begin
         snapshot[rx_status_pkg::SEQ_SUMMARY_BIT] = seqFlag[readPort];
      end
      snapshot[rx_status_pkg::PARITY_BIT] = parityFlag[readPort];
      snapshot[rx_status_pkg::PASS_BIT] = portPass[readPort];
      snapshot[rx_status_pkg::LOCKED_BIT] = receiverLocked[readPort];
   end

   // read data is captured once per read and held until the next read
   always_comb
   begin
      nxt_rdData = rdData_ff;
      nxt_rdValid = statusRead;
      if (statusRead)
      begin
         nxt_rdData = snapshot;
      end
   end

   always_ff @(posedge clk or negedge resetn)
   begin
      if (!resetn)
      begin
         rdData_ff <= rx_status_pkg::STATUS_RESET;
         rdValid_ff <= rx_status_pkg::FLAG_RESET;
      end
      else
      begin
         rdData_ff <= nxt_rdData;
         rdValid_ff <= nxt_rdValid;
      end
   end

   assign rdData = rdData_ff;
   assign rdValid = rdValid_ff;

endmodule : rx_port_status_one

// >>> rx_status_asserts.sv
`timescale 1ns/1ps
module rx_status_asserts
(
   // clock and reset
   input wire logic clk,
   input wire logic resetn,
   // read port
   input wire logic [1:0] readPort,
   input wire logic statusRead,
   input wire logic [7:0] rdData,
   input wire logic rdValid,
   // receiver side
   input wire logic [3:0] enhancedFaultEnable,
   input wire logic [3:0][15:0] parityLimit,
   input wire logic [3:0][15:0] parityFaultCount,
   input wire logic [3:0] ctrlChannelCrcFault,
   input wire logic [3:0] ctrlChannelSequenceFault,
   input wire logic [3:0] receiverLocked,
   input wire logic [3:0] portPass
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);
   // quiet port between two reads, since an event would win over the clear
   sequence readPair(logic [3:0] ev);
      statusRead && !ev[readPort] ##1 !statusRead && !ev[readPort] && $stable(readPort)
         ##1 statusRead && $stable(readPort);
   endsequence
   a_valid_follows: assert property (statusRead |=> rdValid)
      else $error("valid missing");
   a_valid_cause: assert property (rdValid |-> $past(statusRead))
      else $error("stray valid");
   a_port_field: assert property (statusRead |=> rdData[7:6] == $past(readPort))
      else $error("port field wrong");
   a_pass_live: assert property (statusRead |=> rdData[1] == $past(portPass[readPort]))
      else $error("pass bit wrong");
   a_lock_live: assert property
      (statusRead |=> rdData[0] == $past(receiverLocked[readPort]))
      else $error("lock bit wrong");
   a_crc_cleared: assert property (readPair(ctrlChannelCrcFault) |=> !rdData[5])
      else $error("crc flag not cleared");
   a_seq_cleared: assert property
      (readPair(ctrlChannelSequenceFault | enhancedFaultEnable) |=> !rdData[3])
      else $error("sequence flag not cleared");
   a_parity_flag: assert property (statusRead && $stable(readPort) &&
      $past(parityFaultCount[readPort] > parityLimit[readPort]) |=> rdData[2])
      else $error("parity flag missing");
endmodule : rx_status_asserts

bind rx_port_status_one rx_status_asserts chk (.*);

// >>> far_serializer.sv
`timescale 1ns/1ps
// far-side serializer: one-cycle error pulses, steered to the port being read
module far_serializer
(
   // clock
   input wire logic clk,
   // request
   input wire logic [2:0] errReq,
   input wire logic [1:0] readPort,
   // error pulses
   output logic [3:0] ctrlChannelCrcFault,
   output logic [3:0] ctrlChannelSequenceFault,
   output logic [3:0] ctrlChannelAnyFault
);
   always_ff @(posedge clk)
   begin
      ctrlChannelCrcFault <= errReq[0] ? 4'(1 << readPort) : 4'h0;
      ctrlChannelSequenceFault <= errReq[1] ? 4'(1 << readPort) : 4'h0;
      ctrlChannelAnyFault <= errReq[2] ? 4'(1 << readPort) : 4'h0;
   end
endmodule : far_serializer

// >>> tb.sv
`timescale 1ns/1ps
module tb;
   logic clk = '0, resetn = '0, statusRead = '0, detailRead = '0, rdValid;
   logic [1:0] readPort = '0;
   logic [7:0] rdData;
   logic [2:0] errReq = '0;
   logic [3:0] enhancedFaultEnable = '0, parityCountClear = '0, receiverLocked = '0, portPass = '0;
   logic [3:0] ctrlChannelCrcFault, ctrlChannelSequenceFault, ctrlChannelAnyFault;
   logic [3:0][15:0] parityLimit = '0, parityFaultCount = '0;
   logic [31:0] seed = 32'h0000_5c03, r;
   int num_errors = 0, checks = 0;
   always #2.5 clk = ~clk;
   far_serializer far (.*);
   rx_port_status_one uut (.*);
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction : xs
   function automatic logic [7:0] ex(logic [5:0] f);
      return {readPort, f};
   endfunction : ex
   task automatic chk(string n, logic [7:0] e, logic [7:0] g);
      checks++;
      if (g !== e)
      begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   // also ends a pending pulse request, so a read can land on its pulse
   task automatic rd(logic [5:0] f);
      @(negedge clk);
      errReq = 3'h0;
      statusRead = 1'b1;
      @(negedge clk);
      statusRead = 1'b0;
      chk("rdValid", 8'h01, {7'h00, rdValid});
      chk("rdData", ex(f), rdData);
   endtask : rd
   // pulses, then waits out the two-cycle request-to-flag latency of the error pulses
   task automatic kick(logic [2:0] e, logic [3:0] c, logic d);
      @(negedge clk);
      errReq = e;
      parityCountClear = c;
      detailRead = d;
      @(negedge clk);
      errReq = 3'h0;
      parityCountClear = 4'h0;
      detailRead = 1'b0;
      repeat (3) @(negedge clk);
   endtask : kick
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks, num_errors);
      if (num_errors == 0 && checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask : stop_test
   initial
   begin
      #5000;
      num_errors++;
      stop_test();
   end
   initial
   begin
      repeat (10) @(negedge clk);
      resetn = 1'b1;
      for (int p = 0; p < 4; p++)
      begin
         r = xs();
         readPort = p[1:0];
         receiverLocked[p] = r[0];
         portPass[p] = r[1];
         parityLimit[p] = {1'b0, r[30:16]};
         parityFaultCount[p] = parityLimit[p] + 16'(r[2]);
         kick(3'h3, 4'h0, 1'b0);
         rd({1'b1, r[0], 1'b1, r[2], r[1], r[0]});
         rd({3'h0, r[2], r[1], r[0]});
         // crc pulse lands on the read: the clear must not swallow it
         @(negedge clk);
         errReq = 3'h1;
         rd({3'h0, r[2], r[1], r[0]});
         rd({3'h4, r[2], r[1], r[0]});
         enhancedFaultEnable[p] = 1'b1;
         parityFaultCount[p] = 16'h0000;
         kick(3'h4, 4'(1 << p), 1'b0);
         rd({3'h1, 1'b0, r[1], r[0]});
         rd({3'h1, 1'b0, r[1], r[0]});
         kick(3'h0, 4'h0, 1'b1);
         rd({4'h0, r[1], r[0]});
         enhancedFaultEnable[p] = 1'b0;
         $display("port %0d done", p);
      end
      stop_test();
   end
endmodule : tb
